//--- index_modify_address_convert_unit.sv
// Index modify and byte/word address convert unit of the data address generators.
//
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module index_modify_address_convert_unit (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Classic Wishbone slave.
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Decoded instruction from the sequencer.
	input wire logic instr_valid,
	input wire dag_modify_pkg::instr_t instr,
	// Execution results, one cycle after the instruction, and the circular buffer enable bit of the control register.
	output dag_modify_pkg::result_t result,
	output logic circular_buffer_global_enable
);

	// ==========================================================
	// State.
	logic [31:0] idx_ff [8];
	logic [31:0] mod_ff [8];
	logic [31:0] base_ff [8];
	logic [31:0] len_ff [8];
	logic [1:0] ctrl_ff;
	logic illegal_ff;
	dag_modify_pkg::space_t last_space_ff;
	dag_modify_pkg::result_t result_ff;
	logic ack_ff;
	logic [31:0] rdata_ff;

	// ==========================================================
	// Condition evaluation.
	wire uncond = instr.cond == dag_modify_pkg::COND_ALWAYS;
	wire true_x = uncond | instr.cond_x;
	wire true_y = uncond | instr.cond_y;
	wire simd = ctrl_ff[dag_modify_pkg::CTRL_SIMD_BIT];
	// In single element mode only the x element's outcome counts.
	wire exec_idx = instr_valid & (simd ? (true_x | true_y) : true_x);
	// The compact variant never carries a compute operation.
	wire comp_ok = instr.has_compute & (instr.op != dag_modify_pkg::OP_MODIFY_COMPACT);
	wire nxt_comp_x = instr_valid & comp_ok & true_x;
	wire nxt_comp_y = instr_valid & comp_ok & simd & true_y;

	// ==========================================================
	// Operand selection by generator group.
	wire [2:0] src_i = {instr.group, instr.src};
	wire [2:0] mod_i = {instr.group, instr.mod_sel};
	wire is_conv = instr.op == dag_modify_pkg::OP_ADDRESS_CONVERT_OP;
	// The compact form always writes its named destination.
	wire use_dst = instr.has_dest | (instr.op == dag_modify_pkg::OP_MODIFY_COMPACT);
	wire [2:0] dst_i = use_dst ? {instr.group, instr.dst} : src_i;
	wire conv_base = is_conv & instr.base_sel;
	wire [31:0] src_val = conv_base ? base_ff[src_i] : idx_ff[src_i];
	wire [31:0] m_val = mod_ff[mod_i];
	wire [31:0] b_val = base_ff[src_i];
	wire [31:0] l_val = len_ff[src_i];

	// ==========================================================
	// Shared range decoder for scaling, fault and conversion.
	function automatic dag_modify_pkg::space_t classify(input logic [31:0] a);
		if (a >= dag_modify_pkg::BW_BASE) begin
			classify = dag_modify_pkg::SP_BYTE;
		end else if (a >= dag_modify_pkg::SW_BASE) begin
			classify = dag_modify_pkg::SP_SHORT;
		end else if (a >= dag_modify_pkg::NW_BASE) begin
			classify = dag_modify_pkg::SP_NORMAL;
		end else begin
			classify = dag_modify_pkg::SP_LONG;
		end
	endfunction

	dag_modify_pkg::space_t src_space;
	assign src_space = classify(src_val);
	wire in_byte = src_space == dag_modify_pkg::SP_BYTE;
	wire in_norm = src_space == dag_modify_pkg::SP_NORMAL;

	// ==========================================================
	// Modify value scaling and illegal space detection.
	wire sc_sw = instr.modify_scaling_field == dag_modify_pkg::SCALE_SW;
	wire sc_nw = instr.modify_scaling_field == dag_modify_pkg::SCALE_NW;
	wire [31:0] m_sw = {m_val[30:0], 1'b0};
	wire [31:0] m_nw = in_byte ? {m_val[29:0], 2'b00} : m_val;
	wire [31:0] m_scaled = sc_sw ? m_sw : (sc_nw ? m_nw : m_val);
	wire bad_sw = sc_sw & ~in_byte;
	wire bad_nw = sc_nw & ~in_byte & ~in_norm;
	wire illegal = ~is_conv & (bad_sw | bad_nw);

	// ==========================================================
	// Modify with circular wraparound whenever a length is set.
	// The wrap ignores the global enable, which only matters for
	// post-modify memory accesses handled elsewhere.
	wire [31:0] sum = src_val + m_scaled;
	wire [31:0] top = b_val + l_val;
	wire circ = l_val != 32'h0000_0000;
	wire neg = m_scaled[31];
	wire [31:0] wrap_dn = sum - l_val;
	wire [31:0] wrap_up = sum + l_val;
	wire over = ~neg & (sum >= top);
	wire under = neg & (sum < b_val);
	wire [31:0] mod_res = !circ ? sum : (over ? wrap_dn : (under ? wrap_up : sum));

	// ==========================================================
	// Byte/word address conversion.
	wire [31:0] b_off = src_val - dag_modify_pkg::BW_BASE;
	wire [31:0] w_off = src_val - dag_modify_pkg::NW_BASE;
	wire [31:0] to_word = {2'b00, b_off[31:2]} + dag_modify_pkg::NW_BASE;
	wire [31:0] to_byt = {w_off[29:0], 2'b00} + dag_modify_pkg::BW_BASE;
	// Values already in the requested space pass through untouched.
	wire [31:0] conv_res = instr.to_byte ? (in_byte ? src_val : to_byt) :
		(in_byte ? to_word : src_val);

	// ==========================================================
	// Write-back decode.
	wire [31:0] new_val = is_conv ? conv_res : mod_res;
	wire do_write = exec_idx & ~illegal;
	wire wr_idx = do_write & ~conv_base;
	wire wr_base = do_write & conv_base;
	wire raise_illegal = exec_idx & illegal;

	// ==========================================================
	// Bus decode.
	wire bus_req = cyc_i & stb_i;
	wire bus_wr = bus_req & we_i & ~ack_ff;
	wire [2:0] region = adr_i[7:5];
	wire [2:0] entry = adr_i[4:2];
	wire wr_ctrl = bus_wr && (adr_i == dag_modify_pkg::CTRL_ADDR);
	wire wr_stat = bus_wr && (adr_i == dag_modify_pkg::STATUS_ADDR);
	wire wr_reg_i = bus_wr && (region == dag_modify_pkg::REGION_IDX);
	wire wr_reg_m = bus_wr && (region == dag_modify_pkg::REGION_MOD);
	wire wr_reg_b = bus_wr && (region == dag_modify_pkg::REGION_BASE);
	wire wr_reg_l = bus_wr && (region == dag_modify_pkg::REGION_LEN);
	wire [31:0] lane_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	wire [31:0] stat_word = {28'h0000000, last_space_ff, 1'b0, illegal_ff};
	wire [31:0] ctrl_word = {30'h00000000, ctrl_ff};
	wire [31:0] csr_rd = (adr_i == dag_modify_pkg::CTRL_ADDR) ? ctrl_word :
		((adr_i == dag_modify_pkg::STATUS_ADDR) ? stat_word : 32'h0000_0000);
	wire [31:0] nxt_rdata = (region == dag_modify_pkg::REGION_CSR) ? csr_rd :
		(region == dag_modify_pkg::REGION_IDX) ? idx_ff[entry] :
		(region == dag_modify_pkg::REGION_MOD) ? mod_ff[entry] :
		(region == dag_modify_pkg::REGION_BASE) ? base_ff[entry] :
		(region == dag_modify_pkg::REGION_LEN) ? len_ff[entry] : 32'h0000_0000;

	// ==========================================================
	// Per-entry register storage; an instruction write wins over a
	// bus write to the same entry so that program flow stays exact.
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_entry
			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					idx_ff[gi] <= 32'h0000_0000;
					base_ff[gi] <= 32'h0000_0000;
					len_ff[gi] <= 32'h0000_0000;
					mod_ff[gi] <= 32'h0000_0000;
				end else begin
					if (wr_idx && dst_i == 3'(gi)) begin
						idx_ff[gi] <= new_val;
					end else if (wr_reg_i && entry == 3'(gi)) begin
						idx_ff[gi] <= merge(idx_ff[gi], dat_i, lane_mask);
					end
					if (wr_base && dst_i == 3'(gi)) begin
						base_ff[gi] <= new_val;
					end else if (wr_reg_b && entry == 3'(gi)) begin
						base_ff[gi] <= merge(base_ff[gi], dat_i, lane_mask);
					end
					if (wr_reg_l && entry == 3'(gi)) begin
						len_ff[gi] <= merge(len_ff[gi], dat_i, lane_mask);
					end
					// Only software writes a modify register.
					if (wr_reg_m && entry == 3'(gi)) begin
						mod_ff[gi] <= merge(mod_ff[gi], dat_i, lane_mask);
					end
				end
			end
		end
	endgenerate

	// ==========================================================
	// Control, sticky status and results.
	// A new fault in the clearing cycle keeps the flag set.
	wire nxt_illegal = raise_illegal | (illegal_ff & ~(wr_stat & sel_i[0] &
		dat_i[dag_modify_pkg::STAT_ILLEGAL_BIT]));
	wire [1:0] nxt_ctrl = wr_ctrl & sel_i[0] ? dat_i[1:0] : ctrl_ff;
	dag_modify_pkg::result_t nxt_result;
	assign nxt_result = '{compute_x: nxt_comp_x, compute_y: nxt_comp_y,
		updated: do_write, illegal_address_space: raise_illegal};

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ctrl_ff <= dag_modify_pkg::CTRL_RESET;
			illegal_ff <= 1'b0;
			last_space_ff <= dag_modify_pkg::SP_LONG;
			result_ff <= '0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			illegal_ff <= nxt_illegal;
			last_space_ff <= do_write ? classify(new_val) : last_space_ff;
			result_ff <= nxt_result;
		end
	end

	// Classic single-cycle answer: ack one cycle after the strobe.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ack_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= bus_req & ~ack_ff;
			rdata_ff <= nxt_rdata;
		end
	end

	// ==========================================================
	// Outputs.
	assign ack_o = ack_ff;
	assign dat_o = rdata_ff;
	assign result = result_ff;
	assign circular_buffer_global_enable = ctrl_ff[dag_modify_pkg::CTRL_CBUF_BIT];

endmodule

//--- dag_modify_pkg.sv
// Constants, types and register map for the index modify and address convert unit.
// How it works
// - Condition 11111 means unconditional execution.
// - Without destination, sum returns to source index.
// - Source kept if destination given; modify never changes.
// - Index update runs alongside the compute operation.
// - Single element: false condition suppresses everything.
// - Nonzero length always wraps, ignoring global enable.
// - Short-word scaling doubles the modify value.
// - Short-word scaling flags non-byte index illegal.
// - Normal-word scaling: word unscaled, byte times four.
// - Normal-word scaling flags long/short-word index illegal.
// - Scaling field: 00 none, 01 short, 10 normal.
// - Group bit picks first or second generator.
// - Dual element: each compute gated by own condition.
// - Dual element: index updates on OR of conditions.
// - Compact variant: no compute, explicit destination always.
// - Convert byte to word, or word to byte.
// - Value already in target space copies unchanged.
// - Convert fields: base select, direction, group.
// - Convert is wide form; compute runs concurrently.
package dag_modify_pkg;

	// ==========================================================
	// Register map (byte addresses on the register bus).
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;
	localparam logic [2:0] REGION_CSR = 3'h0;
	localparam logic [2:0] REGION_IDX = 3'h1;
	localparam logic [2:0] REGION_MOD = 3'h2;
	localparam logic [2:0] REGION_BASE = 3'h3;
	localparam logic [2:0] REGION_LEN = 3'h4;
	localparam int CTRL_CBUF_BIT = 0;
	localparam int CTRL_SIMD_BIT = 1;
	localparam int STAT_ILLEGAL_BIT = 0;
	localparam int STAT_SPACE_LSB = 2;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	// ==========================================================
	// Address space ranges and instruction constants.
	localparam logic [31:0] NW_BASE = 32'h0010_0000;
	localparam logic [31:0] SW_BASE = 32'h0020_0000;
	localparam logic [31:0] BW_BASE = 32'h0040_0000;
	localparam logic [4:0] COND_ALWAYS = 5'h1F;
	localparam logic [1:0] SCALE_NONE = 2'h0;
	localparam logic [1:0] SCALE_SW = 2'h1;
	localparam logic [1:0] SCALE_NW = 2'h2;

	// ==========================================================
	// Types.
	typedef enum logic [1:0] {SP_LONG, SP_NORMAL, SP_SHORT, SP_BYTE} space_t;
	typedef enum logic [1:0] {OP_MODIFY, OP_MODIFY_COMPACT, OP_ADDRESS_CONVERT_OP} op_t;

	typedef struct packed {
		op_t op;
		logic [4:0] cond;
		logic cond_x;
		logic cond_y;
		logic has_compute;
		logic [1:0] modify_scaling_field;
		logic group;
		logic [1:0] src;
		logic [1:0] mod_sel;
		logic has_dest;
		logic [1:0] dst;
		logic base_sel;
		logic to_byte;
	} instr_t;

	typedef struct packed {
		logic compute_x;
		logic compute_y;
		logic updated;
		logic illegal_address_space;
	} result_t;

endpackage

//--- imac_assertions.sv
// Concurrent checks on the instruction side of the index modify unit.
`timescale 1ns/1ps
module imac_checker (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Instruction and its result.
	input wire logic instr_valid,
	input wire dag_modify_pkg::instr_t instr,
	input wire dag_modify_pkg::result_t result
);
	// ==========================================================
	// Decode of the accepted instruction; every check looks one cycle later.
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire logic uncond = instr_valid && instr.cond == dag_modify_pkg::COND_ALWAYS;
	wire logic gated = instr_valid && instr.cond != dag_modify_pkg::COND_ALWAYS;
	wire logic is_mod = instr.op == dag_modify_pkg::OP_MODIFY;
	wire logic plain = instr.modify_scaling_field == 2'h0;

	AST_UNCOND_COMPUTE: assert property (
		uncond && is_mod && instr.has_compute |=> result.compute_x)
		else $error("Unconditional compute missing");
	AST_FALSE_SUPPRESS: assert property (
		gated && !instr.cond_x && !instr.cond_y |=> result == '0)
		else $error("False condition left activity");
	AST_X_GATED: assert property (
		gated && !instr.cond_x |=> !result.compute_x)
		else $error("X compute ran on false condition");
	AST_Y_GATED: assert property (
		gated && !instr.cond_y |=> !result.compute_y)
		else $error("Y compute ran on false condition");
	AST_COMPACT_NO_COMPUTE: assert property (
		instr_valid && instr.op == dag_modify_pkg::OP_MODIFY_COMPACT
		|=> !result.compute_x && !result.compute_y)
		else $error("Compact form enabled compute");
	AST_CONCURRENT_UPDATE: assert property (
		uncond && is_mod && plain && instr.has_compute
		|=> result.compute_x && result.updated)
		else $error("Update and compute not together");
	AST_ADDRESS_CONVERT_OP_TOGETHER: assert property (
		uncond && instr.op == dag_modify_pkg::OP_ADDRESS_CONVERT_OP
		|=> result.updated && !result.illegal_address_space)
		else $error("Conversion not written");
	AST_NO_SCALE_LEGAL: assert property (
		instr_valid && plain |=> !result.illegal_address_space)
		else $error("Unscaled modify flagged illegal");
endmodule
bind index_modify_address_convert_unit imac_checker u_chk (.ref_clk, .rst_n, .instr_valid,
	.instr, .result);

//--- imac_seq_model.sv
// Sequencer model that issues decoded instructions to the unit.
`timescale 1ns/1ps
module seq_model (
	// Clock, reset and request from the bench.
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic go,
	input wire dag_modify_pkg::instr_t req,
	// Instruction toward the unit.
	output logic instr_valid,
	output dag_modify_pkg::instr_t instr
);
	// One-cycle issue; idle cycles invert every field so stale fields never look valid.
	always_ff @(posedge ref_clk) begin
		instr_valid <= rst_n & go;
		instr <= (go | !rst_n) ? req : ~instr;
	end
endmodule

//--- tb_top.sv
// Self-checking bench for the index modify and address convert unit.
`timescale 1ns/1ps
module tb_top;
	// ==========================================================
	// Signals, aliases and register set-up table.
	localparam dag_modify_pkg::op_t MOD = dag_modify_pkg::OP_MODIFY;
	localparam dag_modify_pkg::op_t CNV = dag_modify_pkg::OP_ADDRESS_CONVERT_OP;
	localparam dag_modify_pkg::op_t CPT = dag_modify_pkg::OP_MODIFY_COMPACT;
	logic ref_clk = 1'h0, rst_n = 1'h0, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0, go = 1'h0;
	logic [7:0] adr_i = 8'h0;
	logic [3:0] sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0, dat_o, q;
	logic ack_o, instr_valid, circular_buffer_global_enable;
	dag_modify_pkg::instr_t req = '0, instr;
	dag_modify_pkg::result_t result;
	int err_total = 0;
	int cmp_count = 0;
	logic [39:0] setup [9] = '{40'h20_00400000, 40'h40_00000005, 40'h34_00100010,
		40'h58_00000003, 40'h2C_00200000, 40'h28_0010000E, 40'h48_00000004,
		40'h68_00100000, 40'h88_00000010};

	// Design, sequencer model and the 25 ns clock.
	index_modify_address_convert_unit u_dut (.ref_clk, .rst_n, .cyc_i, .stb_i, .we_i, .adr_i,
		.sel_i, .dat_i, .dat_o, .ack_o, .instr_valid, .instr, .result,
		.circular_buffer_global_enable);
	seq_model u_seq (.ref_clk, .rst_n, .go, .req, .instr_valid, .instr);
	always #12.5 ref_clk = ~ref_clk;

	// ==========================================================
	// Tasks.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One classic cycle; the request holds until ack is sampled, then idles a cycle.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, d};
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack_o !== 1'h1 && n < 20);
		q = dat_o;
		{cyc_i, stb_i} <= 2'h0;
		@(posedge ref_clk);
		if (n >= 20) begin
			check(32'h1, 32'h0);
			tally_and_finish();
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d);
		bus(1'h0, a, 32'h0);
		check(q, d);
	endtask

	// Issue one instruction, check its result pulse, then read back one register.
	task automatic run(input dag_modify_pkg::op_t o, input logic [1:0] sc, input logic [7:0] f,
		input logic [4:0] x, input logic [3:0] e, input logic [7:0] a, input logic [31:0] d);
		dag_modify_pkg::instr_t n;
		n = '0;
		n.op = o;
		n.cond = x[4] ? 5'h00 : dag_modify_pkg::COND_ALWAYS;
		{n.base_sel, n.to_byte, n.cond_x, n.cond_y} = x[3:0];
		n.has_compute = 1'h1;
		n.modify_scaling_field = sc;
		{n.group, n.src, n.mod_sel, n.has_dest, n.dst} = f;
		req <= n;
		go <= 1'h1;
		@(posedge ref_clk);
		go <= 1'h0;
		// The result pulse launched one edge earlier still stands at this edge.
		repeat (2) @(posedge ref_clk);
		check({28'h0, result}, {28'h0, e});
		rd(a, d);
	endtask

	task automatic tally_and_finish();
		if (err_total == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Main sequence: reset, set-up, then one instruction per case.
	initial begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'h1;
		@(posedge ref_clk);
		rd(8'h00, 32'h0);
		bus(1'h1, 8'hFC, 32'hA5A5A5A5);
		rd(8'hFC, 32'h0);
		foreach (setup[k]) bus(1'h1, setup[k][39:32], setup[k][31:0]);
		run(MOD, 2'h0, 8'hB0, 5'h00, 4'hA, 8'h34, 32'h100013);
		rd(8'h58, 32'h3);
		rd(8'h24, 32'h0);
		run(MOD, 2'h0, 8'hB7, 5'h00, 4'hA, 8'h3C, 32'h100016);
		run(MOD, 2'h1, 8'h00, 5'h00, 4'hA, 8'h20, 32'h40000A);
		run(MOD, 2'h1, 8'hB0, 5'h00, 4'h9, 8'h34, 32'h100013);
		bus(1'h0, 8'h04, 32'h0);
		check({31'h0, q[0]}, 32'h1);
		run(MOD, 2'h2, 8'h00, 5'h00, 4'hA, 8'h20, 32'h40001E);
		run(MOD, 2'h2, 8'hB0, 5'h00, 4'hA, 8'h34, 32'h100016);
		run(MOD, 2'h2, 8'h20, 5'h00, 4'h9, 8'h24, 32'h0);
		run(MOD, 2'h2, 8'h60, 5'h00, 4'h9, 8'h2C, 32'h200000);
		run(MOD, 2'h0, 8'h50, 5'h00, 4'hA, 8'h28, 32'h100002);
		run(MOD, 2'h0, 8'h00, 5'h10, 4'h0, 8'h20, 32'h40001E);
		run(MOD, 2'h0, 8'h00, 5'h12, 4'hA, 8'h20, 32'h400023);
		bus(1'h1, 8'h00, 32'h3);
		check({31'h0, circular_buffer_global_enable}, 32'h1);
		run(MOD, 2'h0, 8'h00, 5'h11, 4'h6, 8'h20, 32'h400028);
		run(CNV, 2'h0, 8'h00, 5'h00, 4'hE, 8'h20, 32'h10000A);
		run(CNV, 2'h0, 8'h00, 5'h00, 4'hE, 8'h20, 32'h10000A);
		run(CNV, 2'h0, 8'h00, 5'h04, 4'hE, 8'h20, 32'h400028);
		run(CNV, 2'h0, 8'h40, 5'h0C, 4'hE, 8'h68, 32'h400000);
		run(CNV, 2'h0, 8'hA0, 5'h04, 4'hE, 8'h34, 32'h400058);
		run(CPT, 2'h0, 8'h03, 5'h00, 4'h2, 8'h2C, 32'h40002D);
		tally_and_finish();
	end
endmodule
